// [src/bkrcs_defs.svh]
/*
  Offsets, field positions, reset values and timing counts for the breaker
  control and status monitor. Assumes a 50 MHz logic clock.
*/
`ifndef BKRCS_DEFS_SVH
`define BKRCS_DEFS_SVH

`define BKRCS_NUM_BKR 2
`define BKRCS_NAME_CHARS 6
`define BKRCS_CLK_HZ 50000000
// Register offsets (byte addresses, one 32-bit word each)
`define BKRCS_OFS_CTRL0 8'h00
`define BKRCS_OFS_CTRL1 8'h04
`define BKRCS_OFS_DELAY0 8'h08
`define BKRCS_OFS_DELAY1 8'h0C
`define BKRCS_OFS_HOLD 8'h10
`define BKRCS_OFS_STATUS0 8'h14
`define BKRCS_OFS_STATUS1 8'h18
`define BKRCS_OFS_IRQ_STAT 8'h1C
`define BKRCS_OFS_IRQ_CLR 8'h20
`define BKRCS_OFS_IRQ_EN 8'h24
`define BKRCS_OFS_NAME0_LO 8'h28
`define BKRCS_OFS_NAME0_HI 8'h2C
`define BKRCS_OFS_NAME1_LO 8'h30
`define BKRCS_OFS_NAME1_HI 8'h34
// Control field positions
`define BKRCS_CTRL_FUNC_EN 0
`define BKRCS_CTRL_PB_EN 1
`define BKRCS_CTRL_SINGLE_POLE 2
// Status field positions
`define BKRCS_ST_POS_A 0
`define BKRCS_ST_POS_B 1
`define BKRCS_ST_POS_C 2
`define BKRCS_ST_CLOSED 3
`define BKRCS_ST_DISAGREE 4
`define BKRCS_ST_ALARM 5
`define BKRCS_ST_OOS 6
`define BKRCS_ST_LOCAL 7
`define BKRCS_ST_HOLD 8
// Interrupt bits per breaker (breaker instance n uses bits 4n..4n+3)
`define BKRCS_IRQ_DISAGREE 0
`define BKRCS_IRQ_ALARM 1
`define BKRCS_IRQ_OPEN 2
`define BKRCS_IRQ_CLOSE 3
// Reset values
`define BKRCS_CTRL_RST 32'h00000000
`define BKRCS_DELAY_RST_MS 32'h00000064
`define BKRCS_HOLD_RST_MS 32'h000000C8
// Timing: delays programmed in milliseconds, counted with a 1 ms tick
`define BKRCS_TICK_MS 1
`define BKRCS_TICK_CYCLES ((`BKRCS_CLK_HZ / 1000) * `BKRCS_TICK_MS)

`endif

// [src/bkrcs_pkg.sv]
/*
  Types shared by the breaker control and status monitor.
  Assumes bkrcs_defs.svh supplies the numeric constants.
*/
package bkrcs_pkg;
  typedef logic [31:0] bkrcs_word_t;
  typedef logic [7:0] bkrcs_addr_t;
  typedef enum logic [0:0] {BKRCS_AGREE, BKRCS_TIMING} bkrcs_dis_state_t;
endpackage

// [src/bkrcs_top.sv]
/*
  Breaker control and status monitor: two breaker instances turning logic
  operands into open/close contact commands, tracking pole position and
  timing pole disagreement, with a simple strobe register port.
  Assumes operand inputs come from outside the clock domain (synchronised
  here) and that the register master keeps the strobe protocol.
*/
// The plain strobed port and the register addresses were decided locally.
`include "bkrcs_defs.svh"

module bkrcs_top
  import bkrcs_pkg::*;
#(
  parameter int TICK_CYCLES = `BKRCS_TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [1:0] open_req_in,
  input wire logic [1:0] close_req_in,
  input wire logic [1:0] pb_open_in,
  input wire logic [1:0] pb_close_in,
  input wire logic [1:0] manual_close_in,
  input wire logic [1:0] track_a_in,
  input wire logic [1:0] track_b_in,
  input wire logic [1:0] track_c_in,
  input wire logic [1:0] external_alarm_select_in,
  input wire logic [1:0] out_of_service_select_in,
  input wire logic [1:0] local_ctrl_in,
  output logic [1:0] open_cmd_out,
  output logic [1:0] close_cmd_out,
  output logic [1:0] closed_out,
  output logic [1:0] disagree_out,
  output logic [1:0] alarm_out,
  output logic [1:0] out_of_service_out,
  output logic [1:0] local_ctrl_out,
  output logic [1:0] manual_close_hold_out,
  output logic irq_out
);

  localparam int NB = `BKRCS_NUM_BKR;
  localparam int NIN = 8;

  function automatic logic hit(input bkrcs_addr_t a, input bkrcs_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // Two-stage synchronisers for every operand bus
  logic [NIN*NB-1:0] raw;
  logic [NIN*NB-1:0] sync1_q;
  logic [NIN*NB-1:0] sync2_q;
  assign raw = {open_req_in, close_req_in, pb_open_in, pb_close_in, manual_close_in,
                track_a_in, track_b_in, track_c_in};
  // Alarm, out-of-service and local-control operands have their own pair of stages
  logic [5:0] sync_aux1_q;
  logic [5:0] sync_aux2_q;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync_aux1_q <= '0;
      sync_aux2_q <= '0;
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      sync_aux1_q <= {external_alarm_select_in, out_of_service_select_in, local_ctrl_in};
      sync_aux2_q <= sync_aux1_q;
    end
  end

  logic [1:0] s_open, s_close, s_pbo, s_pbc, s_man, s_ta, s_tb, s_tc, s_alm, s_oos, s_loc;
  assign {s_open, s_close, s_pbo, s_pbc, s_man, s_ta, s_tb, s_tc} = sync2_q;
  assign {s_alm, s_oos, s_loc} = sync_aux2_q;

  // Millisecond tick shared by all timers
  logic [31:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Software-visible configuration
  bkrcs_word_t ctrl_q [NB];
  bkrcs_word_t delay_q [NB];
  bkrcs_word_t name_lo_q [NB];
  bkrcs_word_t name_hi_q [NB];
  bkrcs_word_t hold_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_evt;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NB; i++)
      begin
        ctrl_q[i] <= `BKRCS_CTRL_RST;
        delay_q[i] <= `BKRCS_DELAY_RST_MS;
      end
    end
    else if (wr_in)
    begin
      // Only the three defined control bits are kept; the rest read as zero
      if (hit(addr_in, `BKRCS_OFS_CTRL0)) ctrl_q[0] <= {29'h0, wdata_in[2:0]};
      if (hit(addr_in, `BKRCS_OFS_CTRL1)) ctrl_q[1] <= {29'h0, wdata_in[2:0]};
      if (hit(addr_in, `BKRCS_OFS_DELAY0)) delay_q[0] <= wdata_in;
      if (hit(addr_in, `BKRCS_OFS_DELAY1)) delay_q[1] <= wdata_in;
    end
  end

  // Manual close hold time, shared by both breakers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      hold_q <= `BKRCS_HOLD_RST_MS;
    else if (wr_in && hit(addr_in, `BKRCS_OFS_HOLD))
      hold_q <= wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      irq_en_q <= 8'h00;
    else if (wr_in && hit(addr_in, `BKRCS_OFS_IRQ_EN))
      irq_en_q <= wdata_in[7:0];
  end

  // Labels: 4 chars in low word, 2 chars in high word; only software reads them
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NB; i++)
      begin
        name_lo_q[i] <= 32'h00000000;
        name_hi_q[i] <= 32'h00000000;
      end
    end
    else if (wr_in)
    begin
      if (hit(addr_in, `BKRCS_OFS_NAME0_LO)) name_lo_q[0] <= wdata_in;
      if (hit(addr_in, `BKRCS_OFS_NAME0_HI)) name_hi_q[0] <= {16'h0, wdata_in[15:0]};
      if (hit(addr_in, `BKRCS_OFS_NAME1_LO)) name_lo_q[1] <= wdata_in;
      if (hit(addr_in, `BKRCS_OFS_NAME1_HI)) name_hi_q[1] <= {16'h0, wdata_in[15:0]};
    end
  end

  // Per-breaker logic; instance 0 is breaker 1 and works alone
  logic [NB-1:0] closed_d, dis_raw, dis_q, alm_q, open_q, close_q, hold_act;
  logic [31:0] dis_cnt_q [NB];
  logic [32:0] hold_cnt_q [NB];
  bkrcs_dis_state_t dis_st_q [NB];
  logic [2:0] pole [NB];

  generate
    for (genvar b = 0; b < NB; b++)
    begin : g_bkr
      logic en, pb, sp;
      assign en = ctrl_q[b][`BKRCS_CTRL_FUNC_EN];
      assign pb = ctrl_q[b][`BKRCS_CTRL_PB_EN];
      assign sp = ctrl_q[b][`BKRCS_CTRL_SINGLE_POLE];
      // Low is open, high is closed; B and C follow A in three-pole mode
      assign pole[b][0] = s_ta[b];
      assign pole[b][1] = sp ? s_tb[b] : s_ta[b];
      assign pole[b][2] = sp ? s_tc[b] : s_ta[b];
      assign closed_d[b] = sp ? (&pole[b]) : s_ta[b];
      assign dis_raw[b] = en && sp && !((&pole[b]) || !(|pole[b]));

      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          open_q[b] <= 1'b0;
          close_q[b] <= 1'b0;
        end
        else
        begin
          // Open takes priority over a simultaneous close for safety
          open_q[b] <= en && (s_open[b] || (pb && s_pbo[b]));
          close_q[b] <= en && !(s_open[b] || (pb && s_pbo[b]))
                        && (s_close[b] || (pb && s_pbc[b]));
        end
      end

      // Alarm indication follows the alarm operand while the breaker is enabled
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          alm_q[b] <= 1'b0;
        else
          alm_q[b] <= en && s_alm[b];
      end

      // Disagreement must persist strictly longer than the delay in ms ticks
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          dis_st_q[b] <= BKRCS_AGREE;
          dis_cnt_q[b] <= '0;
          dis_q[b] <= 1'b0;
        end
        else
        begin
          case (dis_st_q[b])
            BKRCS_AGREE:
            begin
              dis_q[b] <= 1'b0;
              dis_cnt_q[b] <= '0;
              if (dis_raw[b]) dis_st_q[b] <= BKRCS_TIMING;
            end
            BKRCS_TIMING:
            begin
              if (!dis_raw[b])
              begin
                dis_st_q[b] <= BKRCS_AGREE;
                dis_q[b] <= 1'b0;
              end
              else if (tick_q && dis_cnt_q[b] <= delay_q[b])
                dis_cnt_q[b] <= dis_cnt_q[b] + 32'h00000001;
              else if (dis_cnt_q[b] > delay_q[b])
                dis_q[b] <= 1'b1;
            end
            default: dis_st_q[b] <= BKRCS_AGREE;
          endcase
        end
      end

      // Manual close hold interval; loaded one tick long because the first tick
      // comes at any phase, so the hold never falls short of the programmed time
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          hold_cnt_q[b] <= '0;
        else if (en && s_man[b])
          hold_cnt_q[b] <= {1'b0, hold_q} + 33'h000000001;
        else if (!en)
          hold_cnt_q[b] <= '0;
        else if (tick_q && hold_cnt_q[b] != 33'h000000000)
          hold_cnt_q[b] <= hold_cnt_q[b] - 33'h000000001;
      end
      assign hold_act[b] = hold_cnt_q[b] != 33'h000000000;

      // Fires once, in the cycle before the indication is raised
      assign irq_evt[4*b+`BKRCS_IRQ_DISAGREE] = (dis_st_q[b] == BKRCS_TIMING) && dis_raw[b]
                                                && dis_cnt_q[b] > delay_q[b] && !dis_q[b];
      assign irq_evt[4*b+`BKRCS_IRQ_ALARM] = en && s_alm[b] && !alm_q[b];
      assign irq_evt[4*b+`BKRCS_IRQ_OPEN] = 1'b0;
      assign irq_evt[4*b+`BKRCS_IRQ_CLOSE] = 1'b0;
    end
  endgenerate

  // Registered command contacts
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      open_cmd_out <= '0;
      close_cmd_out <= '0;
    end
    else
    begin
      open_cmd_out <= open_q;
      close_cmd_out <= close_q;
    end
  end

  // Registered status indications
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      closed_out <= '0;
      disagree_out <= '0;
      alarm_out <= '0;
      out_of_service_out <= '0;
      local_ctrl_out <= '0;
      manual_close_hold_out <= '0;
    end
    else
    begin
      closed_out <= closed_d;
      disagree_out <= dis_q;
      alarm_out <= alm_q;
      out_of_service_out <= s_oos;
      local_ctrl_out <= s_loc;
      manual_close_hold_out <= hold_act;
    end
  end

  // Sticky events: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      irq_stat_q <= 8'h00;
    else if (wr_in && hit(addr_in, `BKRCS_OFS_IRQ_CLR))
      irq_stat_q <= (irq_stat_q & ~wdata_in[7:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_stat_q & irq_en_q);
  end

  function automatic bkrcs_word_t status_word(input int b);
    bkrcs_word_t w;
    w = '0;
    w[`BKRCS_ST_POS_A] = pole[b][0];
    w[`BKRCS_ST_POS_B] = pole[b][1];
    w[`BKRCS_ST_POS_C] = pole[b][2];
    w[`BKRCS_ST_CLOSED] = closed_d[b];
    w[`BKRCS_ST_DISAGREE] = dis_q[b];
    w[`BKRCS_ST_ALARM] = alm_q[b];
    w[`BKRCS_ST_OOS] = s_oos[b];
    w[`BKRCS_ST_LOCAL] = s_loc[b];
    w[`BKRCS_ST_HOLD] = hold_act[b];
    status_word = w;
  endfunction

  // Read data appear the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      rdata_out <= 32'h00000000;
    else if (rd_in)
    begin
      case (addr_in)
        `BKRCS_OFS_CTRL0: rdata_out <= ctrl_q[0];
        `BKRCS_OFS_CTRL1: rdata_out <= ctrl_q[1];
        `BKRCS_OFS_DELAY0: rdata_out <= delay_q[0];
        `BKRCS_OFS_DELAY1: rdata_out <= delay_q[1];
        `BKRCS_OFS_HOLD: rdata_out <= hold_q;
        `BKRCS_OFS_STATUS0: rdata_out <= status_word(0);
        `BKRCS_OFS_STATUS1: rdata_out <= status_word(1);
        `BKRCS_OFS_IRQ_STAT: rdata_out <= {24'h0, irq_stat_q};
        `BKRCS_OFS_IRQ_EN: rdata_out <= {24'h0, irq_en_q};
        `BKRCS_OFS_NAME0_LO: rdata_out <= name_lo_q[0];
        `BKRCS_OFS_NAME0_HI: rdata_out <= name_hi_q[0];
        `BKRCS_OFS_NAME1_LO: rdata_out <= name_lo_q[1];
        `BKRCS_OFS_NAME1_HI: rdata_out <= name_hi_q[1];
        default: rdata_out <= 32'h00000000;
      endcase
    end
    else
      rdata_out <= 32'h00000000;
  end

endmodule // bkrcs_top

// [testbench/bkrcs_top_chk.sv]
/*
  Port-level assertions for the breaker monitor, breaker 1 mostly.
  Assumes register writes keep the one-cycle strobe protocol.
*/
`include "bkrcs_defs.svh"

module bkrcs_chk
  import bkrcs_pkg::*;
#(
  parameter int TICK_CYCLES = 5
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic [1:0] open_req_in,
  input wire logic [1:0] close_req_in,
  input wire logic [1:0] pb_open_in,
  input wire logic [1:0] track_a_in,
  input wire logic [1:0] track_b_in,
  input wire logic [1:0] track_c_in,
  input wire logic [1:0] external_alarm_select_in,
  input wire logic [1:0] out_of_service_select_in,
  input wire logic [1:0] local_ctrl_in,
  input wire logic [1:0] open_cmd_out,
  input wire logic [1:0] close_cmd_out,
  input wire logic [1:0] closed_out,
  input wire logic [1:0] disagree_out,
  input wire logic [1:0] alarm_out,
  input wire logic [1:0] out_of_service_out,
  input wire logic [1:0] local_ctrl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [2:0] ctl_q;
  logic [31:0] dly_q;
  logic [31:0] cnt_q;
  logic mis;
  assign mis = (track_a_in[0] != track_b_in[0]) || (track_a_in[0] != track_c_in[0]);
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctl_q <= 3'h0;
      dly_q <= `BKRCS_DELAY_RST_MS;
    end
    else if (wr_in && addr_in == `BKRCS_OFS_CTRL0)
      ctl_q <= wdata_in[2:0];
    else if (wr_in && addr_in == `BKRCS_OFS_DELAY0)
      dly_q <= wdata_in;
  end
  // Counts the raw mismatch, which leads the synchronised view, so the bound is safe
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !mis || !(ctl_q[0] && ctl_q[2]))
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end
  sequence s_open;
    (ctl_q[0] && open_req_in[0]) [*5];
  endsequence
  sequence s_close;
    (ctl_q[0] && close_req_in[0] && !open_req_in[0] && !(ctl_q[1] && pb_open_in[0])) [*5];
  endsequence
  sequence s_off;
    (!ctl_q[0]) [*5];
  endsequence
  AST_OPEN: assert property (s_open |-> open_cmd_out[0])
    else $error("open command missing");
  AST_CLOSE: assert property (s_close |-> close_cmd_out[0] && !open_cmd_out[0])
    else $error("close command missing");
  AST_WINS: assert property ((open_cmd_out & close_cmd_out) == 2'b00)
    else $error("open and close together");
  AST_OFF: assert property (s_off |-> !open_cmd_out[0] && !close_cmd_out[0] && !disagree_out[0])
    else $error("disabled breaker active");
  AST_POS3: assert property ((ctl_q[0] && !ctl_q[2] && $stable(track_a_in[0])) [*5]
    |-> closed_out[0] == track_a_in[0] && !disagree_out[0])
    else $error("three-pole position wrong");
  AST_CLR: assert property ((!mis) [*5] |-> !disagree_out[0])
    else $error("disagreement not cleared");
  AST_WAIT: assert property ($rose(disagree_out[0]) |-> cnt_q >= dly_q * TICK_CYCLES)
    else $error("disagreement declared early");
  AST_ALARM: assert property ((ctl_q[0] && external_alarm_select_in[0]) [*5] |-> alarm_out[0])
    else $error("alarm not shown");
  AST_OOS: assert property (out_of_service_select_in[0] [*5] |-> out_of_service_out[0])
    else $error("out of service not shown");
  AST_LOC: assert property (local_ctrl_in[1] [*5] |-> local_ctrl_out[1])
    else $error("local control not shown");
endmodule // bkrcs_chk

bind bkrcs_top bkrcs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .open_req_in(open_req_in), .close_req_in(close_req_in),
  .pb_open_in(pb_open_in),
  .track_a_in(track_a_in), .track_b_in(track_b_in), .track_c_in(track_c_in),
  .external_alarm_select_in(external_alarm_select_in),
  .out_of_service_select_in(out_of_service_select_in), .local_ctrl_in(local_ctrl_in),
  .open_cmd_out(open_cmd_out), .close_cmd_out(close_cmd_out), .closed_out(closed_out),
  .disagree_out(disagree_out), .alarm_out(alarm_out),
  .out_of_service_out(out_of_service_out), .local_ctrl_out(local_ctrl_out)
);

// [testbench/bkrcs_brk_model.sv]
/*
  Two breakers whose three poles follow the open and close contacts.
  Assumes level commands; pole C may be told to lag behind A and B.
*/
module bkrcs_brk_model
(
  input wire logic clk_in,
  input wire logic [1:0] open_cmd_in,
  input wire logic [1:0] close_cmd_in,
  input wire logic [7:0] lag_c_in,
  output logic [1:0] track_a_out,
  output logic [1:0] track_b_out,
  output logic [1:0] track_c_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tgt = 2'b00;
  int cnt [2] = '{0, 0};
  initial
  begin
    track_a_out = 2'b00;
    track_b_out = 2'b00;
    track_c_out = 2'b00;
  end
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (open_cmd_in[i])
        tgt[i] = 1'b0;
      else if (close_cmd_in[i])
        tgt[i] = 1'b1;
      if ({track_a_out[i], track_b_out[i], track_c_out[i]} == {3{tgt[i]}})
        cnt[i] = 0;
      else
        cnt[i] = cnt[i] + 1;
      // Contact reads low while the pole is open
      if (cnt[i] == 3)
      begin
        track_a_out[i] <= tgt[i];
        track_b_out[i] <= tgt[i];
      end
      if (cnt[i] == 3 + int'(lag_c_in))
        track_c_out[i] <= tgt[i];
    end
  end
endmodule // bkrcs_brk_model

// [testbench/breaker_control_status_monitor_tb.sv]
/*
  Self-checking bench for the breaker monitor with the breaker model.
  Assumes the shortened tick of 5 clocks per millisecond.
*/
`include "bkrcs_defs.svh"

module breaker_control_status_monitor_tb
  import bkrcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam bkrcs_addr_t RA [5] = '{`BKRCS_OFS_CTRL0, `BKRCS_OFS_DELAY0, `BKRCS_OFS_HOLD,
    `BKRCS_OFS_IRQ_EN, 8'h3C};
  localparam bkrcs_word_t RV [5] = '{32'h0, 32'h64, 32'hC8, 32'h0, 32'h0};
  logic clk_in, rst_n_in, wr_in, rd_in, irq_out, en1;
  logic [7:0] addr_in, lag;
  logic [31:0] wdata_in, rdata_out, d, d2;
  logic [1:0] open_req_in, close_req_in, pb_open_in, pb_close_in, manual_close_in;
  logic [1:0] ext, oos, loc, ta, tb, tc, open_cmd, close_cmd, closed, dis, alarm, oos_o;
  logic [1:0] loc_o, hold;
  int mismatches, cmp_count, n;
  bkrcs_top #(.TICK_CYCLES(5)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .open_req_in(open_req_in), .close_req_in(close_req_in), .pb_open_in(pb_open_in),
    .pb_close_in(pb_close_in), .manual_close_in(manual_close_in), .track_a_in(ta),
    .track_b_in(tb), .track_c_in(tc), .external_alarm_select_in(ext),
    .out_of_service_select_in(oos), .local_ctrl_in(loc), .open_cmd_out(open_cmd),
    .close_cmd_out(close_cmd), .closed_out(closed), .disagree_out(dis), .alarm_out(alarm),
    .out_of_service_out(oos_o), .local_ctrl_out(loc_o), .manual_close_hold_out(hold),
    .irq_out(irq_out));
  bkrcs_brk_model u_brk (.clk_in(clk_in), .open_cmd_in(open_cmd), .close_cmd_in(close_cmd),
    .lag_c_in(lag), .track_a_out(ta), .track_b_out(tb), .track_c_out(tc));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bkrcs_addr_t a, input bkrcs_word_t v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input bkrcs_addr_t a, output bkrcs_word_t v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // Bounded wait on one watched bit; a timeout ends the run as a failure
  task automatic wait_sig(input int s, input logic v, output int c);
    logic x;
    c = 0;
    do
    begin
      @(posedge clk_in);
      #1 c++;
      x = (s == 0) ? dis[0] : (s == 1) ? ta[0] : hold[0];
    end while (x !== v && c < 300);
    if (c >= 300)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial
  begin
    {rst_n_in, wr_in, rd_in, addr_in, wdata_in, lag} = '0;
    {open_req_in, close_req_in, pb_open_in, pb_close_in, manual_close_in} = '0;
    {ext, oos, loc} = '0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h9FC40A64));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(8'h3C, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++)
    begin
      rd(RA[i], d);
      chk(d, RV[i]);
    end
    @(posedge clk_in) open_req_in <= 2'b11;
    wait_n(6);
    chk(open_cmd, 2'b00);
    wr(`BKRCS_OFS_CTRL0, 32'h1);
    @(posedge clk_in) close_req_in <= 2'b11;
    wait_n(6);
    chk({open_cmd, close_cmd}, 4'h4);
    lag <= 8'd40;
    open_req_in <= 2'b00;
    wait_n(14);
    chk({close_cmd, closed[0], dis[0]}, 4'h6);
    close_req_in <= 2'b00;
    pb_open_in <= 2'b01;
    wait_n(44);
    chk(open_cmd, 2'b00);
    wr(`BKRCS_OFS_CTRL0, 32'h3);
    wait_n(6);
    chk(open_cmd, 2'b01);
    pb_open_in <= 2'b00;
    wait_n(50);
    wr(`BKRCS_OFS_DELAY0, 32'h3);
    wr(`BKRCS_OFS_IRQ_EN, 32'h1);
    wr(`BKRCS_OFS_CTRL0, 32'h5);
    @(posedge clk_in) pb_close_in <= 2'b01;
    wait_n(6);
    chk(close_cmd, 2'b00);
    pb_close_in <= 2'b00;
    close_req_in <= 2'b01;
    wait_sig(1, 1'b1, n);
    wait_sig(0, 1'b1, n);
    chk(n >= 15 && n <= 30, 1);
    chk(irq_out, 1);
    @(posedge clk_in) close_req_in <= 2'b00;
    wait_sig(0, 1'b0, n);
    chk(tc[0], 1);
    rd(`BKRCS_OFS_STATUS0, d);
    chk(d & 32'h1F, 32'hF);
    wr(`BKRCS_OFS_IRQ_CLR, 32'hFF);
    rd(`BKRCS_OFS_IRQ_STAT, d);
    chk({d[0], irq_out}, 2'b00);
    wr(`BKRCS_OFS_HOLD, 32'h2);
    @(posedge clk_in) manual_close_in <= 2'b01;
    @(posedge clk_in) manual_close_in <= 2'b00;
    wait_sig(2, 1'b1, n);
    wait_sig(2, 1'b0, n);
    chk(n >= 10 && n <= 16, 1);
    for (int k = 0; k < 8; k++)
    begin
      en1 = 1'($urandom);
      wr(`BKRCS_OFS_CTRL1, {31'h0, en1});
      @(posedge clk_in);
      ext <= 2'($urandom);
      oos <= 2'($urandom);
      loc <= 2'($urandom);
      wait_n(6);
      chk(alarm, ext & {en1, 1'b1});
      chk(oos_o, oos);
      chk(loc_o, loc);
    end
    @(posedge clk_in) ext <= 2'b00;
    wait_n(6);
    wr(`BKRCS_OFS_IRQ_CLR, 32'hFF);
    @(posedge clk_in) ext <= 2'b01;
    wait_n(6);
    rd(`BKRCS_OFS_IRQ_STAT, d);
    chk({d[5], d[1], irq_out}, 3'b010);
    wr(`BKRCS_OFS_IRQ_EN, 32'h2);
    wait_n(2);
    chk(irq_out, 1);
    d2 = $urandom;
    wr(`BKRCS_OFS_NAME0_LO, d2);
    wr(`BKRCS_OFS_NAME1_HI, 32'hFFFFFFFF);
    rd(`BKRCS_OFS_NAME0_LO, d);
    chk(d, d2);
    rd(`BKRCS_OFS_NAME1_HI, d);
    chk(d, 32'h0000FFFF);
    stop_test();
  end
endmodule // breaker_control_status_monitor_tb
